/* File: hdl/csb_defs.svh */
// Purpose: Offsets, field positions and reset values of the serial port.
// Assumes: Included by bare name.
// Notes:   Definitions only.
`ifndef CSB_DEFS_SVH
`define CSB_DEFS_SVH
// Register offsets on the register port.
`define CSB_A_CTL0     3'h0
`define CSB_A_CTL1     3'h1
`define CSB_A_CTL2     3'h2
`define CSB_A_STAT     3'h3
`define CSB_A_TX       3'h4
`define CSB_A_RX       3'h5
// Main control bit positions.
`define CSB_B_PWR      7
`define CSB_B_TXE      6
`define CSB_B_RXE      5
`define CSB_B_DIR      4
`define CSB_B_TMS      1
`define CSB_B_SCE      0
// Writable bits of main control; bits 3 and 2 read as zero.
`define CSB_CTL0_MASK  8'hf3
`define CSB_CTL1_MASK  8'h1f
`define CSB_CTL2_MASK  8'h0f
// Reset values.
`define CSB_RST_CTL0   8'h01
`define CSB_RST_CTL1   8'h00
`define CSB_RST_CTL2   8'h00
// Clock select code for slave role, and master half period base.
`define CSB_CKS_SLAVE  3'h7
`define CSB_HALF_BASE  8'h02
// Length field: top bit forces 16 bits, else 8 plus low bits.
`define CSB_LEN_BASE   4'h7
`define CSB_LEN_MAX    4'hf
`endif

/* File: hdl/csb_pkg.sv */
// Purpose: Types shared by the serial port modules.
// Assumes: Nothing.
// Notes:   Direction mode is {transmit enable, receive enable}.
package csb_pkg;
   typedef enum logic [1:0] {
      CSB_OFF    = 2'b00,
      CSB_RXONLY = 2'b01,
      CSB_TXONLY = 2'b10,
      CSB_DUPLEX = 2'b11
   } csb_mode_t;
endpackage

/* File: hdl/csb_clk_if.sv */
// Purpose: Carries shift clock control and edge pulses inside the port.
// Assumes: One clock domain.
// Notes:   Edge pulses are registered in the generator.
`timescale 1ns/1ps
interface csb_clk_if;
   logic       run;     // Transfer in progress.
   logic       slave;   // Clock comes from the pin.
   logic [2:0] cks;     // Master divide select.
   logic       sck_in;  // Serial clock pin level.
   logic       rise;    // Sampling edge pulse.
   logic       fall;    // Shifting edge pulse.
   logic       sck;     // Master clock level.
   modport gen  (input run, slave, cks, sck_in, output rise, fall, sck);
   modport core (output run, slave, cks, sck_in, input rise, fall, sck);
endinterface

/* File: hdl/csb_clkgen.sv */
// Purpose: Makes the shift clock edges for master or slave role.
// Assumes: The pin input is synchronous to clk_i.
// Notes:   Clock idles high; falling edge shifts, rising edge samples.
`timescale 1ns/1ps
`include "csb_defs.svh"
module csb_clkgen (
   // Clock and reset.
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Core side.
   csb_clk_if.gen    cif
);
   logic [7:0] cnt_reg;   // Half period counter.
   logic       prev_reg;  // Previous pin level for edge finding.
   logic [7:0] half_m1;   // Last count of a half period.

   // Divide by four times two to the select code.
   assign half_m1 = 8'((`CSB_HALF_BASE << cif.cks) - 8'h01);

   // Pin history for slave edges.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_reg <= 1'b1;
      end else begin
         prev_reg <= cif.sck_in;
      end
   end

   // Clock level, counter and edge pulses.
   always_ff @(posedge clk_i) begin
      if (rst_i || !cif.run) begin
         cnt_reg  <= 8'h00;
         cif.sck  <= 1'b1;
         cif.rise <= 1'b0;
         cif.fall <= 1'b0;
      end else if (cif.slave) begin
         // Nothing moves until the peer makes edges.
         cif.sck  <= 1'b1;
         cif.rise <= cif.sck_in & ~prev_reg;
         cif.fall <= ~cif.sck_in & prev_reg;
      end else if (cnt_reg == half_m1) begin
         cnt_reg  <= 8'h00;
         cif.sck  <= ~cif.sck;
         cif.rise <= ~cif.sck;
         cif.fall <= cif.sck;
      end else begin
         cnt_reg  <= cnt_reg + 8'h01;
         cif.rise <= 1'b0;
         cif.fall <= 1'b0;
      end
   end
endmodule

/* File: hdl/csb_serial_port.sv */
// Purpose: Clocked serial port channel, single transfer mode.
// Assumes: Register strobes last one cycle; pins synchronous to clk_i.
// Notes:   Continuous mode bit is stored but behaves as single mode.
//
// Functional notes
// - Clock select 000 is master, fxx/4
// - Clock select 111 is slave, pin clock
// - Length field zero gives eight bits
// - Transmit write sets busy, starts transfer
// - Duplex write shifts out and in together
// - Receive-only dummy read sets busy, starts
// - Master drives clock, shifts and samples
// - Slave waits for peer clock edges
// - Last edge: stop, interrupt, clear busy
// - Read with trigger set starts next
// - Trigger clear lets read without starting
// - Length 8 to 16, data LSB aligned
// - Data out low while transmit disabled
// - Channel disable clears status and busy
`timescale 1ns/1ps
`include "csb_defs.svh"
module csb_serial_port
   import csb_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Register port.
   input  wire logic [2:0]  addr_i,
   input  wire logic [15:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [15:0] rdata_o,
   // Serial pins.
   input  wire logic        serial_clock_pin_i,
   output logic             serial_clock_pin_o,
   output logic             serial_clock_pin_oe_o,
   output logic             serial_data_out_pin_o,
   input  wire logic        serial_data_in_pin_i,
   // Transfer end event.
   output logic             reception_end_irq_o
);

   ////////////////////////////////////////////////////////////////
   // Declarations.
   ////////////////////////////////////////////////////////////////

   logic [7:0]  serial_main_control_reg;   // Main control.
   logic [7:0]  serial_clock_format_reg;   // Clock format.
   logic [7:0]  serial_length_config_reg;  // Length config.
   logic [15:0] transmit_data_reg;         // Word to send.
   logic [15:0] receive_data_reg;          // Last word received.
   logic [15:0] rx_shift_reg;              // Bits being gathered.
   logic [15:0] rx_shift_next;             // Gathered bits with new one.
   logic        transfer_busy_flag_reg;    // Transfer in progress.
   logic [3:0]  bit_cnt_reg;               // Bits already sampled.
   logic        sdo_reg;                   // Data out pin.
   logic        oe_reg;                    // Clock pin enable.
   logic        irq_reg;                   // End event pulse.
   logic [15:0] rdata_reg;                 // Read answer.

   logic        channel_enable;            // Channel on.
   logic        transmit_enable;           // Transmit on.
   logic        receive_enable;            // Receive on.
   logic        bit_order_select;          // One for LSB first.
   logic        start_trigger_enable;      // Read may start reception.
   logic [2:0]  clock_source_select;       // Divide or slave.
   logic        slave_role;                // External clock.
   csb_mode_t   mode;                      // Direction mode.
   logic [3:0]  len_m1;                    // Bit count minus one.
   logic        tx_start;                  // Start by transmit write.
   logic        rx_start;                  // Start by receive read.
   logic        last_edge;                 // Final sampling edge.
   logic        tx_bit;                    // Bit now presented.

   csb_clk_if   cif ();                    // Clock generator link.

   ////////////////////////////////////////////////////////////////
   // Field decode.
   ////////////////////////////////////////////////////////////////

   // Fields of main control at their fixed places.
   assign channel_enable       = serial_main_control_reg[`CSB_B_PWR];
   assign transmit_enable      = serial_main_control_reg[`CSB_B_TXE];
   assign receive_enable       = serial_main_control_reg[`CSB_B_RXE];
   assign bit_order_select     = serial_main_control_reg[`CSB_B_DIR];
   assign start_trigger_enable = serial_main_control_reg[`CSB_B_SCE];
   assign mode = csb_mode_t'({transmit_enable, receive_enable});

   // Select 111 is slave, the rest divide the core clock.
   assign clock_source_select = serial_clock_format_reg[2:0];
   assign slave_role = (clock_source_select == `CSB_CKS_SLAVE);

   // Length field: zero gives eight bits, top bit sixteen.
   assign len_m1 = serial_length_config_reg[3] ? `CSB_LEN_MAX :
                   ({1'b0, serial_length_config_reg[2:0]} + `CSB_LEN_BASE);

   ////////////////////////////////////////////////////////////////
   // Start triggers and shift edges.
   ////////////////////////////////////////////////////////////////

   // A transmit write starts transmit-only and duplex transfers.
   assign tx_start = wr_i && (addr_i == `CSB_A_TX) && channel_enable &&
                     transmit_enable && !transfer_busy_flag_reg;

   // In receive-only mode a read with the trigger set starts.
   assign rx_start = rd_i && (addr_i == `CSB_A_RX) && channel_enable &&
                     (mode == CSB_RXONLY) && start_trigger_enable &&
                     !transfer_busy_flag_reg;

   // The sampling edge of the last configured bit ends the transfer.
   assign last_edge = cif.rise && transfer_busy_flag_reg &&
                      (bit_cnt_reg == len_m1);

   // Bit on the wire; the word sits at the LSB end in both orders.
   assign tx_bit = bit_order_select ? transmit_data_reg[bit_cnt_reg] :
                   transmit_data_reg[4'(len_m1 - bit_cnt_reg)];

   // New bit merged into the gathered word; unused upper bits stay zero.
   always_comb begin
      if (bit_order_select) begin
         rx_shift_next = rx_shift_reg |
                         (16'(serial_data_in_pin_i) << bit_cnt_reg);
      end else begin
         rx_shift_next = {rx_shift_reg[14:0], serial_data_in_pin_i};
      end
   end

   ////////////////////////////////////////////////////////////////
   // Clock generator.
   ////////////////////////////////////////////////////////////////

   // The generator only runs while busy, so a slave waits for
   // peer edges and a master stops clocking after the last bit.
   assign cif.run    = transfer_busy_flag_reg;
   assign cif.slave  = slave_role;
   assign cif.cks    = clock_source_select;
   assign cif.sck_in = serial_clock_pin_i;

   csb_clkgen u_clkgen (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .cif   (cif)
   );

   ////////////////////////////////////////////////////////////////
   // Control registers.
   ////////////////////////////////////////////////////////////////

   // Main control. Direction, order and mode bits are frozen while
   // the channel stays on; a write that also clears the enable
   // may change them, so one write can shut everything down.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         serial_main_control_reg <= `CSB_RST_CTL0;
      end else if (wr_i && addr_i == `CSB_A_CTL0) begin
         if (!channel_enable || !wdata_i[`CSB_B_PWR]) begin
            serial_main_control_reg <= wdata_i[7:0] & `CSB_CTL0_MASK;
         end else begin
            serial_main_control_reg <= {wdata_i[7],
                                        serial_main_control_reg[6:1],
                                        wdata_i[0]};
         end
      end
   end

   // Clock format only changes while the channel is off.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         serial_clock_format_reg <= `CSB_RST_CTL1;
      end else if (wr_i && addr_i == `CSB_A_CTL1 && !channel_enable) begin
         serial_clock_format_reg <= wdata_i[7:0] & `CSB_CTL1_MASK;
      end
   end

   // Length changes while off or with both directions off.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         serial_length_config_reg <= `CSB_RST_CTL2;
      end else if (wr_i && addr_i == `CSB_A_CTL2 &&
                   (!channel_enable || mode == CSB_OFF)) begin
         serial_length_config_reg <= wdata_i[7:0] & `CSB_CTL2_MASK;
      end
   end

   // Transmit word. Held steady while a transfer runs, since the
   // bit on the wire is picked straight out of it.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         transmit_data_reg <= 16'h0000;
      end else if (wr_i && addr_i == `CSB_A_TX && !transfer_busy_flag_reg) begin
         transmit_data_reg <= wdata_i;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Transfer engine.
   ////////////////////////////////////////////////////////////////

   // Busy flag. Disabling the channel clears it at once.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         transfer_busy_flag_reg <= 1'b0;
      end else if (!channel_enable) begin
         transfer_busy_flag_reg <= 1'b0;
      end else if (tx_start || rx_start) begin
         transfer_busy_flag_reg <= 1'b1;
      end else if (last_edge) begin
         transfer_busy_flag_reg <= 1'b0;
      end
   end

   // Bit counter, advanced on each sampling edge but the last.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bit_cnt_reg <= 4'h0;
      end else if (tx_start || rx_start) begin
         bit_cnt_reg <= 4'h0;
      end else if (cif.rise && transfer_busy_flag_reg && !last_edge) begin
         bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
   end

   // Input sampling on the rising edge, in every mode.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_shift_reg <= 16'h0000;
      end else if (tx_start || rx_start) begin
         rx_shift_reg <= 16'h0000;
      end else if (cif.rise && transfer_busy_flag_reg) begin
         rx_shift_reg <= rx_shift_next;
      end
   end

   // Received word is kept only with receive enabled.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         receive_data_reg <= 16'h0000;
      end else if (last_edge && receive_enable) begin
         receive_data_reg <= rx_shift_next;
      end
   end

   // End pulse, also in transmit-only mode.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= last_edge;
      end
   end

   // Data out follows the bit counter; low with transmit off.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sdo_reg <= 1'b0;
      end else begin
         sdo_reg <= transmit_enable & tx_bit;
      end
   end

   // Clock pin is driven only by an enabled master.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         oe_reg <= 1'b0;
      end else begin
         oe_reg <= channel_enable & ~slave_role;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Register read port.
   ////////////////////////////////////////////////////////////////

   // Answer stands one cycle after the read strobe, zero otherwise.
   always_ff @(posedge clk_i) begin
      if (rst_i || !rd_i) begin
         rdata_reg <= 16'h0000;
      end else begin
         unique case (addr_i)
            `CSB_A_CTL0: rdata_reg <= {8'h00, serial_main_control_reg};
            `CSB_A_CTL1: rdata_reg <= {8'h00, serial_clock_format_reg};
            `CSB_A_CTL2: rdata_reg <= {8'h00, serial_length_config_reg};
            `CSB_A_STAT: rdata_reg <= {15'h0000, transfer_busy_flag_reg};
            `CSB_A_TX:   rdata_reg <= transmit_data_reg;
            `CSB_A_RX:   rdata_reg <= receive_data_reg;
            default:     rdata_reg <= 16'h0000;
         endcase
      end
   end

   // Outputs, each from a flip-flop.
   assign rdata_o               = rdata_reg;
   assign serial_clock_pin_o    = cif.sck;
   assign serial_clock_pin_oe_o = oe_reg;
   assign serial_data_out_pin_o = sdo_reg;
   assign reception_end_irq_o   = irq_reg;

   ////////////////////////////////////////////////////////////////
   // Checks.
   ////////////////////////////////////////////////////////////////

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_slave_no_drive: assert property (
      slave_role |=> !serial_clock_pin_oe_o)
      else $error("Slave drives the clock pin.");

   a_sdo_low_txoff: assert property (
      !transmit_enable |=> !serial_data_out_pin_o)
      else $error("Data out not low with transmit off.");

   a_off_clears_busy: assert property (
      !channel_enable |=> !transfer_busy_flag_reg)
      else $error("Busy survives channel disable.");

   a_tx_write_start: assert property (
      (wr_i && addr_i == `CSB_A_TX && channel_enable && transmit_enable &&
       !transfer_busy_flag_reg) |=> transfer_busy_flag_reg)
      else $error("Transmit write did not start.");

   a_rx_read_start: assert property (
      (rd_i && addr_i == `CSB_A_RX && channel_enable && mode == CSB_RXONLY &&
       start_trigger_enable && !transfer_busy_flag_reg)
      |=> transfer_busy_flag_reg)
      else $error("Dummy read did not start.");

   a_no_trig_read: assert property (
      (rd_i && addr_i == `CSB_A_RX && !start_trigger_enable &&
       !transfer_busy_flag_reg) |=> !transfer_busy_flag_reg)
      else $error("Read with trigger off started.");

   a_irq_end_busy: assert property (
      reception_end_irq_o |-> !transfer_busy_flag_reg ##1 !reception_end_irq_o)
      else $error("End pulse with busy or too long.");

   // The low phase lasts two cycles; a transfer cut by disable may end it early.
   a_master_div4: assert property (
      ($fell(serial_clock_pin_o) && !slave_role && clock_source_select == 3'h0)
      |=> !transfer_busy_flag_reg or (!serial_clock_pin_o ##1 serial_clock_pin_o))
      else $error("Master half period is not two cycles.");

   a_len8_ends: assert property (
      ($rose(transfer_busy_flag_reg) && !slave_role &&
       clock_source_select == 3'h0 && serial_length_config_reg == 8'h00)
      |-> ##[1:40] (reception_end_irq_o || !channel_enable))
      else $error("Eight bit transfer did not end.");

   a_rx_aligned: assert property (
      (last_edge && receive_enable && len_m1 == 4'h7)
      |=> receive_data_reg[15:8] == 8'h00)
      else $error("Short word not LSB aligned.");

   c_tx_only:  cover property (tx_start && mode == CSB_TXONLY);
   c_rx_only:  cover property (rx_start);
   c_duplex:   cover property (last_edge && mode == CSB_DUPLEX);
   c_slave_in: cover property (cif.rise && slave_role);
endmodule

/* File: test/csb_peer_model.sv */
// Purpose: Serial peer on the far side of the port, master or slave of the link.
// Assumes: Pins are sampled on clk_i; the bench loads a word before each frame.
// Notes:   Outside a frame the data line toggles every cycle so stale bits never look valid.
`timescale 1ns/1ps
module csb_peer_model (
   // Clock and reset.
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Bench control.
   input  wire logic        load_i,
   input  wire logic        go_i,
   input  wire logic [4:0]  len_i,
   input  wire logic [15:0] word_i,
   // Link pins.
   input  wire logic        sck_pin_i,
   input  wire logic        sdo_i,
   output logic             sck_o,
   output logic             sdi_o,
   output logic      [15:0] rx_o
);
   logic       prev_reg;   // Clock pin level one cycle ago.
   logic [4:0] idx_reg;    // Index of the next bit to present.
   logic       frame_reg;  // High while a frame is in flight.
   logic [5:0] half_reg;   // Half periods still to make.
   logic [1:0] div_reg;    // Cycle count within a half period.
   ////////////////////////////////////////////////////////////////////////////////
   // Clock maker: idles high and runs only inside a frame, four cycles a half.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sck_o    <= 1'b1;
         half_reg <= 6'h00;
         div_reg  <= 2'h0;
      end else if (go_i) begin
         half_reg <= {len_i, 1'b0};
         div_reg  <= 2'h0;
      end else if (half_reg != 6'h00) begin
         div_reg <= div_reg + 2'h1;
         if (div_reg == 2'h3) begin
            sck_o    <= ~sck_o;
            half_reg <= half_reg - 6'h01;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Data: present a bit at each fall, capture the device bit at each rise.
   always_ff @(posedge clk_i) begin
      prev_reg <= sck_pin_i;
      if (rst_i) begin
         frame_reg <= 1'b0;
         sdi_o     <= 1'b0;
         rx_o      <= 16'h0000;
         idx_reg   <= 5'h00;
      end else if (load_i) begin
         idx_reg   <= len_i - 5'h01;
         frame_reg <= 1'b1;
         rx_o      <= 16'h0000;
      end else begin
         // Changing at the fall keeps the bit steady across the sampling rise.
         if (prev_reg && !sck_pin_i && frame_reg) begin
            sdi_o   <= word_i[idx_reg[3:0]];
            idx_reg <= idx_reg - 5'h01;
         end else if (!frame_reg) begin
            sdi_o <= ~sdi_o;
         end
         if (!prev_reg && sck_pin_i) begin
            rx_o <= {rx_o[14:0], sdo_i};
            if (idx_reg == 5'h1f) begin
               frame_reg <= 1'b0;
            end
         end
      end
   end
endmodule

/* File: test/csb_serial_port_tb.sv */
// Purpose: Self-checking bench for the serial port in single transfer mode.
// Assumes: Register strobes are one cycle; the peer model closes the link.
// Notes:   Each scenario is its own task and judges its own results.
`timescale 1ns/1ps
`include "csb_defs.svh"
module csb_serial_port_tb;
   logic        clk_i = 1'b0;     // Core clock, 8 ns.
   logic        rst_i = 1'b1;     // Synchronous reset.
   logic [2:0]  addr_i = 3'h0;    // Register offset.
   logic [15:0] wdata_i = 16'h0;  // Write data.
   logic        wr_i = 1'b0;      // Write strobe.
   logic        rd_i = 1'b0;      // Read strobe.
   logic [15:0] rdata_o;          // Read data.
   logic        sck_dev, sck_oe, sck_peer, sck_pin, sdo, sdi, irq;
   logic        load = 1'b0;      // Peer word load.
   logic        go = 1'b0;        // Peer clock start.
   logic [4:0]  len = 5'h08;      // Peer frame length.
   logic [15:0] word = 16'h0;     // Peer transmit word.
   logic [15:0] peer_rx;          // Word the peer captured.
   logic [15:0] d;                // Scratch read value.
   int          err_count = 0;
   int          comparisons = 0;
   // The pin carries whoever drives it; the peer clock idles high otherwise.
   assign sck_pin = sck_oe ? sck_dev : sck_peer;
   always #4 clk_i = ~clk_i;
   csb_serial_port csb_serial_port_i (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .serial_clock_pin_i(sck_pin), .serial_clock_pin_o(sck_dev),
      .serial_clock_pin_oe_o(sck_oe), .serial_data_out_pin_o(sdo), .serial_data_in_pin_i(sdi),
      .reception_end_irq_o(irq));
   csb_peer_model csb_peer_model_i (.clk_i(clk_i), .rst_i(rst_i), .load_i(load), .go_i(go), .len_i(len),
      .word_i(word), .sck_pin_i(sck_pin), .sdo_i(sdo), .sck_o(sck_peer), .sdi_o(sdi), .rx_o(peer_rx));
   ////////////////////////////////////////////////////////////////////////////////
   // Shared helpers.
   task automatic complete_run;
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [15:0] v);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= v;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so sample just then.
   task automatic rdc(input logic [2:0] a, input logic [15:0] exp);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk(rdata_o, exp);
   endtask
   task automatic peer(input logic [4:0] n, input logic [15:0] w, input logic g);
      @(posedge clk_i);
      load <= 1'b1;
      len  <= n;
      word <= w;
      go   <= g;
      @(posedge clk_i);
      load <= 1'b0;
      go   <= 1'b0;
   endtask
   // Bounded wait for the end pulse; a missing pulse shows as a mismatch.
   task automatic wait_irq;
      int n;
      n = 0;
      @(posedge clk_i);
      #1;
      while (irq !== 1'b1 && n < 400) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      chk({15'h0, irq}, 16'h0001);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios.
   task automatic t_reset;
      rdc(`CSB_A_CTL0, 16'h0001);
      rdc(`CSB_A_CTL1, 16'h0000);
      rdc(`CSB_A_CTL2, 16'h0000);
      rdc(3'h6, 16'h0000);
      chk({14'h0, sck_oe, sdo}, 16'h0000);
   endtask
   // Master transmit; a second word written while busy must be dropped.
   task automatic t_tx_master;
      wr(`CSB_A_CTL1, 16'h0000);
      wr(`CSB_A_CTL2, 16'h0000);
      wr(`CSB_A_CTL0, 16'h00c1);
      peer(5'h08, 16'h0000, 1'b0);
      wr(`CSB_A_TX, 16'h00a5);
      rdc(`CSB_A_STAT, 16'h0001);
      chk({15'h0, sck_oe}, 16'h0001);
      wr(`CSB_A_TX, 16'h00ff);
      wait_irq();
      rdc(`CSB_A_STAT, 16'h0000);
      chk({8'h0, peer_rx[7:0]}, 16'h00a5);
      peer(5'h08, 16'h0000, 1'b0);
      wr(`CSB_A_TX, 16'h003c);
      wait_irq();
      chk({8'h0, peer_rx[7:0]}, 16'h003c);
   endtask
   // Duplex with twelve bits: LSB aligned, upper receive bits read as zero.
   task automatic t_duplex;
      wr(`CSB_A_CTL0, 16'h0000);
      wr(`CSB_A_CTL2, 16'h0004);
      wr(`CSB_A_CTL0, 16'h00e1);
      peer(5'h0c, 16'h0abc, 1'b0);
      wr(`CSB_A_TX, 16'hf123);
      wait_irq();
      chk({4'h0, peer_rx[11:0]}, 16'h0123);
      rdc(`CSB_A_RX, 16'h0abc);
      peer(5'h0c, 16'h0555, 1'b0);
      wr(`CSB_A_TX, 16'h0aaa);
      wait_irq();
      rdc(`CSB_A_RX, 16'h0555);
      chk({4'h0, peer_rx[11:0]}, 16'h0aaa);
      // LSB first: the peer shifts MSB first, so both words arrive bit-reversed.
      wr(`CSB_A_CTL0, 16'h0000);
      wr(`CSB_A_CTL0, 16'h00f1);
      peer(5'h0c, 16'h0003, 1'b0);
      wr(`CSB_A_TX, 16'h0001);
      wait_irq();
      rdc(`CSB_A_RX, 16'h0c00);
      chk({4'h0, peer_rx[11:0]}, 16'h0800);
   endtask
   // Receive only: dummy read starts, read with trigger restarts, cleared trigger does not.
   task automatic t_rx_master;
      wr(`CSB_A_CTL0, 16'h0000);
      wr(`CSB_A_CTL2, 16'h0000);
      wr(`CSB_A_CTL0, 16'h00a1);
      peer(5'h08, 16'h0096, 1'b0);
      rdc(`CSB_A_RX, 16'h0c00);
      rdc(`CSB_A_STAT, 16'h0001);
      chk({15'h0, sdo}, 16'h0000);
      wait_irq();
      peer(5'h08, 16'h0069, 1'b0);
      rdc(`CSB_A_RX, 16'h0096);
      rdc(`CSB_A_STAT, 16'h0001);
      wait_irq();
      wr(`CSB_A_CTL0, 16'h00a0);
      rdc(`CSB_A_RX, 16'h0069);
      rdc(`CSB_A_STAT, 16'h0000);
   endtask
   // Slave duplex: nothing moves until the peer supplies the clock.
   task automatic t_slave;
      wr(`CSB_A_CTL0, 16'h0000);
      wr(`CSB_A_CTL1, 16'h0007);
      wr(`CSB_A_CTL0, 16'h00e1);
      wr(`CSB_A_TX, 16'h005e);
      repeat (20) @(posedge clk_i);
      rdc(`CSB_A_STAT, 16'h0001);
      chk({14'h0, sck_oe, irq}, 16'h0000);
      peer(5'h08, 16'h00c3, 1'b1);
      wait_irq();
      chk({8'h0, peer_rx[7:0]}, 16'h005e);
      rdc(`CSB_A_RX, 16'h00c3);
   endtask
   // Disabling mid-transfer clears busy and no end pulse follows.
   task automatic t_abort;
      int n;
      n = 0;
      wr(`CSB_A_CTL0, 16'h0000);
      wr(`CSB_A_CTL1, 16'h0000);
      wr(`CSB_A_CTL0, 16'h00c1);
      wr(`CSB_A_TX, 16'h0033);
      repeat (6) @(posedge clk_i);
      wr(`CSB_A_CTL0, 16'h0000);
      rdc(`CSB_A_STAT, 16'h0000);
      chk({14'h0, sck_oe, sdo}, 16'h0000);
      repeat (60) begin
         @(posedge clk_i);
         #1;
         if (irq !== 1'b0) n++;
      end
      chk(n[15:0], 16'h0000);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence and watchdog; the whole run needs well under a thousand cycles.
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_tx_master();
      t_duplex();
      t_rx_master();
      t_slave();
      t_abort();
      complete_run();
   end
   initial begin
      repeat (5000) @(posedge clk_i);
      err_count++;
      complete_run();
   end
endmodule
